//--- bench/hpc_cfg_host.sv
`timescale 1ns/1ns
module hpc_cfg_host
(
  // Clock
  input wire logic clk,
  // Register port
  output hpc_pkg::hpc_req_t req,
  input wire logic [7:0] rdata
);
  initial req = '0;

  // Released bus shows inverted values, never the last ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit obey);
  begin
    @(posedge clk);
    #1;
    if (obey && a == 8'h0B) d = d & 8'h0E;
    if (obey && (a == 8'h0C || a == 8'h0E) && d > 8'h32) d = 8'h32;
    req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1;
    req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
  end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
  begin
    @(posedge clk);
    #1;
    req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: ~req.wdata};
    @(posedge clk);
    #1;
    d = rdata;
    req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~req.wdata};
  end
  endtask : rd
endmodule : hpc_cfg_host

//--- bench/hpc_power_regs_tb_top.sv
`timescale 1ns/1ns
module hpc_power_regs_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cfg = 1'b0, dyn = 1'b0, sense = 1'b0, comp = 1'b0, start = 1'b0;
  logic good;
  logic [7:0] rdata, a, d, got;
  hpc_pkg::hpc_req_t req;
  hpc_pkg::hpc_power_t power;
  logic [7:0] e [6];
  integer seed = 32'h2922;
  int num_errors = 0;
  int comparisons = 0;

  hpc_power_regs dut (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
    .self_powered_cfg(cfg), .dynamic_enable(dyn), .local_supply_sense(sense),
    .compound_device(comp), .port_power_start(start), .port_power_good(good),
    .power(power));
  hpc_cfg_host host (.clk(clk), .req(req), .rdata(rdata));

  initial forever #10 clk = ~clk;

  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    stop_test;
  end

  task automatic stop_test;
  begin
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  end
  endtask : stop_test

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
  begin
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask : chk

  function automatic logic [7:0] exp_rd(input logic [7:0] x);
    return (x >= 8'h0B && x <= 8'h10) ? e[x - 8'h0B] : 8'h00;
  endfunction : exp_rd

  task automatic do_reset;
  begin
    reset = 1'b1;
    foreach (e[i]) e[i] = 8'h00;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
  end
  endtask : do_reset

  task automatic read_all;
    logic [7:0] x;
  begin
    for (int i = 0; i < 9; i++)
    begin
      x = (i == 8) ? 8'hFF : 8'h0A + 8'(i);
      host.rd(x, got);
      chk(10'(got), 10'(exp_rd(x)));
    end
  end
  endtask : read_all

  task automatic check_power;
    logic s;
    logic [2:0] pe;
    logic [7:0] mp, cc;
  begin
    s = dyn ? sense : cfg;
    pe = s ? 3'h7 : ~e[0][3:1];
    mp = s ? e[1] : e[2];
    cc = s ? e[3] : e[4];
    chk(10'(power.self_mode), 10'(s));
    chk(10'(power.port_enable), 10'(pe));
    chk(10'(power.max_power), 10'(mp));
    chk(10'(power.ctrl_current), 10'(cc));
    chk(power.max_power_ma, {1'b0, mp, 1'b0});
    chk(power.ctrl_current_ma, {1'b0, cc, 1'b0});
  end
  endtask : check_power

  initial
  begin
    do_reset;
    chk(10'(good), 10'h000);
    read_all;
    check_power;
    // Corner cases: 50 counts, reserved bits, undefined writes
    cfg = 1'b1;
    host.wr(8'h0C, 8'h32, 1'b1);
    e[1] = 8'h32;
    host.rd(8'h0C, got);
    chk(10'(got), 10'h032);
    chk(power.max_power_ma, 10'h064);
    host.wr(8'h0B, 8'hFF, 1'b0);
    e[0] = 8'h0E;
    foreach (e[i]) host.wr(8'h0A + 8'(i * 7 % 9), 8'hA5, 1'b0);
    host.wr(8'hFF, 8'h5A, 1'b0);
    // Sweep hits 0x0A, 0x11, 0x0F, 0x0D, 0x0B, 0x12; only mapped ones land
    e[0] = 8'h04;
    e[2] = 8'hA5;
    e[4] = 8'hA5;
    cfg = 1'b0;
    read_all;
    check_power;
    for (int i = 0; i < 40; i++)
    begin
      {cfg, dyn, sense, comp} = 4'($random(seed));
      a = 8'h0A + {5'h00, 3'($random(seed))};
      d = 8'($random(seed));
      if (a == 8'h0C || a == 8'h0E) d = d % 8'h33;
      host.wr(a, d, 1'b1);
      if (a >= 8'h0B && a <= 8'h10) e[a - 8'h0B] = (a == 8'h0B) ? d & 8'h0E : d;
      host.rd(a, got);
      chk(10'(got), 10'(exp_rd(a)));
      check_power;
    end
    // Power-good delay of zero, then a nonzero delay that must not finish early
    host.wr(8'h10, 8'h00, 1'b1);
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    @(posedge clk);
    #1;
    chk(10'(good), 10'h001);
    host.wr(8'h10, 8'h01, 1'b1);
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    repeat (50) @(posedge clk);
    #1;
    chk(10'(good), 10'h000);
    do_reset;
    chk(10'(good), 10'h000);
    read_all;
    stop_test;
  end
endmodule : hpc_power_regs_tb_top

//--- logic/hpc_delay_timer.sv
`timescale 1ns/1ns
module hpc_delay_timer
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sequence control
  input wire logic start,
  input wire logic [7:0] delay_count,
  // Result
  output logic power_good
);

  typedef struct packed {
    logic [7:0] units;
    logic [16:0] cycles;
    logic running;
    logic good;
  } hpc_timer_state_t;

  hpc_timer_state_t s_q;
  hpc_timer_state_t s_d;

  // ****************************************************************
  // Count the delay in 2 ms units
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    if (start)
    begin
      s_d.units = delay_count;
      s_d.cycles = 17'h00000;
      s_d.running = (delay_count != 8'h00);
      s_d.good = (delay_count == 8'h00);
    end
    else if (s_q.running)
    begin
      if (s_q.cycles == 17'(hpc_pkg::CYCLES_PER_COUNT - 1))
      begin
        s_d.cycles = 17'h00000;
        s_d.units = s_q.units - 8'h01;
        if (s_q.units == 8'h01)
        begin
          s_d.running = 1'b0;
          s_d.good = 1'b1;
        end
      end
      else
      begin
        s_d.cycles = s_q.cycles + 17'h00001;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign power_good = s_q.good;

endmodule : hpc_delay_timer

//--- logic/hpc_pkg.sv
package hpc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_BUS_PORT_DISABLE = 8'h0B;
  localparam logic [7:0] ADDR_SELF_MAX_POWER = 8'h0C;
  localparam logic [7:0] ADDR_BUS_MAX_POWER = 8'h0D;
  localparam logic [7:0] ADDR_SELF_CTRL_CURRENT = 8'h0E;
  localparam logic [7:0] ADDR_BUS_CTRL_CURRENT = 8'h0F;
  localparam logic [7:0] ADDR_POWER_GOOD_DELAY = 8'h10;

  // ****************************************************************
  // Reset values and field layout
  // ****************************************************************
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] UNDEF_READ_VALUE = 8'h00;
  localparam logic [7:0] PORT_DISABLE_MASK = 8'h0E;
  localparam int PORT_COUNT = 3;
  localparam int PORT_FIRST_BIT = 1;

  // ****************************************************************
  // Units
  // ****************************************************************
  localparam int MA_PER_COUNT = 2;
  localparam int MS_PER_COUNT = 2;
  localparam int CLK_MHZ = 50;
  localparam int CYCLES_PER_MS = CLK_MHZ * 1000;
  localparam int CYCLES_PER_COUNT = MS_PER_COUNT * CYCLES_PER_MS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] port_disable;
    logic [7:0] self_max_power;
    logic [7:0] bus_max_power;
    logic [7:0] self_ctrl_current;
    logic [7:0] bus_ctrl_current;
    logic [7:0] power_good_delay;
  } hpc_regs_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hpc_req_t;

  typedef struct packed {
    logic [PORT_COUNT-1:0] port_enable;
    logic [7:0] max_power;
    logic [7:0] ctrl_current;
    logic [9:0] max_power_ma;
    logic [9:0] ctrl_current_ma;
    logic self_mode;
  } hpc_power_t;

endpackage : hpc_pkg

//--- logic/hpc_power_regs.sv
// Functional notes
// - In bus-powered operation, bits 1..3 of port disable register set disable downstream ports 1..3.
// - Port disable bit 0 reads zero; bits 4 to 7 are reserved.
// - Self-powered max power is 8 bits in 2 mA units.
// - Bus-powered max power is 8 bits in 2 mA units.
// - Power and current values decode linearly at 2 mA per count.
// - Max power includes an embedded compound peripheral reporting zero current.
// - Self-powered controller current is 8 bits, 2 mA, hub only.
// - Bus-powered controller current is 8 bits, 2 mA, hub only.
// - Power-on time register holds port power-good delay in 2 ms units.
// - All six registers reset to 0x00.
// - Reads of undefined addresses return 0x00.
// - Writes to undefined addresses change nothing and raise no error.
// - With dynamic switching, power sense input selects the register set.
`timescale 1ns/1ns
module hpc_power_regs
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire hpc_pkg::hpc_req_t req,
  output logic [7:0] rdata,
  // Mode selection
  input wire logic self_powered_cfg,
  input wire logic dynamic_enable,
  input wire logic local_supply_sense,
  input wire logic compound_device,
  // Port power sequence
  input wire logic port_power_start,
  output logic port_power_good,
  // Power state toward hub core
  output hpc_pkg::hpc_power_t power
);

  typedef struct packed {
    hpc_pkg::hpc_regs_t regs;
    logic [7:0] rdata;
    hpc_pkg::hpc_power_t power;
  } hpc_state_t;

  hpc_state_t s_q;
  hpc_state_t s_d;
  logic self_sel;
  logic timer_good;
  logic [hpc_pkg::PORT_COUNT-1:0] port_en;

  // ****************************************************************
  // Power source selection
  // ****************************************************************
  assign self_sel = dynamic_enable ? local_supply_sense : self_powered_cfg;

  // ****************************************************************
  // Per-port enable from the bus-powered disable mask
  // ****************************************************************
  for (genvar i = 0; i < hpc_pkg::PORT_COUNT; i++)
  begin : g_port
    // Disable applies only in bus-powered operation
    assign port_en[i] = self_sel |
      ~s_q.regs.port_disable[i + hpc_pkg::PORT_FIRST_BIT];

    chk_port_gate_each: assert property (@(posedge clk) disable iff (reset)
      !self_sel |=> power.port_enable[i] ==
        !$past(s_q.regs.port_disable[i + hpc_pkg::PORT_FIRST_BIT]))
      else $error("port enable does not follow disable bit");
  end

  // ****************************************************************
  // Register writes, reads and derived outputs
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    if (req.wr_en)
    begin
      // Unmapped writes fall through with no effect, no error
      case (req.addr)
        hpc_pkg::ADDR_BUS_PORT_DISABLE:
          s_d.regs.port_disable = req.wdata & hpc_pkg::PORT_DISABLE_MASK;
        hpc_pkg::ADDR_SELF_MAX_POWER:
          s_d.regs.self_max_power = req.wdata;
        hpc_pkg::ADDR_BUS_MAX_POWER:
          s_d.regs.bus_max_power = req.wdata;
        hpc_pkg::ADDR_SELF_CTRL_CURRENT:
          s_d.regs.self_ctrl_current = req.wdata;
        hpc_pkg::ADDR_BUS_CTRL_CURRENT:
          s_d.regs.bus_ctrl_current = req.wdata;
        hpc_pkg::ADDR_POWER_GOOD_DELAY:
          s_d.regs.power_good_delay = req.wdata;
        default:
          s_d.regs = s_q.regs;
      endcase
    end
    if (req.rd_en)
    begin
      case (req.addr)
        hpc_pkg::ADDR_BUS_PORT_DISABLE:
          s_d.rdata = s_q.regs.port_disable;
        hpc_pkg::ADDR_SELF_MAX_POWER:
          s_d.rdata = s_q.regs.self_max_power;
        hpc_pkg::ADDR_BUS_MAX_POWER:
          s_d.rdata = s_q.regs.bus_max_power;
        hpc_pkg::ADDR_SELF_CTRL_CURRENT:
          s_d.rdata = s_q.regs.self_ctrl_current;
        hpc_pkg::ADDR_BUS_CTRL_CURRENT:
          s_d.rdata = s_q.regs.bus_ctrl_current;
        hpc_pkg::ADDR_POWER_GOOD_DELAY:
          s_d.rdata = s_q.regs.power_good_delay;
        default:
          s_d.rdata = hpc_pkg::UNDEF_READ_VALUE;
      endcase
    end
    s_d.power.self_mode = self_sel;
    s_d.power.port_enable = port_en;
    // Max power figure covers a compound peripheral, controller figure does not
    s_d.power.max_power = self_sel ? s_q.regs.self_max_power
                                   : s_q.regs.bus_max_power;
    s_d.power.ctrl_current = self_sel ? s_q.regs.self_ctrl_current
                                      : s_q.regs.bus_ctrl_current;
    s_d.power.max_power_ma = 10'(s_d.power.max_power * hpc_pkg::MA_PER_COUNT);
    s_d.power.ctrl_current_ma =
      10'(s_d.power.ctrl_current * hpc_pkg::MA_PER_COUNT);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q.regs <= {6{hpc_pkg::RESET_VALUE}};
      s_q.rdata <= hpc_pkg::RESET_VALUE;
      s_q.power <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Port power-good delay
  // ****************************************************************
  hpc_delay_timer u_timer
  (
    .clk(clk),
    .reset(reset),
    .start(port_power_start),
    .delay_count(s_q.regs.power_good_delay),
    .power_good(timer_good)
  );

  assign port_power_good = timer_good;
  assign rdata = s_q.rdata;
  assign power = s_q.power;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_undef_read_zero: assert property (@(posedge clk) disable iff (reset)
    req.rd_en && !(req.addr inside {[8'h0B:8'h10]}) |=> rdata == 8'h00)
    else $error("undefined read not zero");

  chk_undef_write_none: assert property (@(posedge clk) disable iff (reset)
    req.wr_en && !(req.addr inside {[8'h0B:8'h10]}) |=> $stable(s_q.regs))
    else $error("undefined write changed a register");

  chk_reserved_bits_zero: assert property (@(posedge clk) disable iff (reset)
    (s_q.regs.port_disable & 8'hF1) == 8'h00)
    else $error("reserved port disable bit set");

  chk_port_disable_map: assert property (@(posedge clk) disable iff (reset)
    !self_sel && s_q.regs.port_disable[2] |=> !power.port_enable[1])
    else $error("port 2 not disabled");

  chk_write_readback: assert property (@(posedge clk) disable iff (reset)
    req.wr_en && req.addr == 8'h0C && !req.rd_en ##1 !req.wr_en ##1 req.rd_en && !req.wr_en
      && req.addr == 8'h0C |=> rdata == $past(req.wdata, 3))
    else $error("self max power readback mismatch");

  chk_linear_decode: assert property (@(posedge clk) disable iff (reset)
    power.max_power_ma == {1'b0, power.max_power, 1'b0})
    else $error("power decode not 2 mA per count");

  chk_dynamic_select: assert property (@(posedge clk) disable iff (reset)
    dynamic_enable && !local_supply_sense |=> !power.self_mode)
    else $error("dynamic select ignored sense input");

  chk_bus_select: assert property (@(posedge clk) disable iff (reset)
    !dynamic_enable && !self_powered_cfg |=> power.max_power == $past(s_q.regs.bus_max_power))
    else $error("bus max power not selected");

  chk_ctrl_select: assert property (@(posedge clk) disable iff (reset)
    !self_sel |=> power.ctrl_current == $past(s_q.regs.bus_ctrl_current))
    else $error("bus controller current not selected");

  chk_reset_zero: assert property (@(posedge clk)
    reset |=> s_q.regs == '0)
    else $error("register not zero after reset");

  chk_reset_outputs: assert property (@(posedge clk)
    reset |=> rdata == 8'h00 && power == '0 && !port_power_good)
    else $error("outputs not cleared by reset");

  chk_linear_current: assert property (@(posedge clk) disable iff (reset)
    power.ctrl_current_ma == {1'b0, power.ctrl_current, 1'b0})
    else $error("current decode not 2 mA per count");

  chk_dynamic_self: assert property (@(posedge clk) disable iff (reset)
    dynamic_enable && local_supply_sense |=> power.self_mode)
    else $error("dynamic select ignored sense input");

  chk_self_select: assert property (@(posedge clk) disable iff (reset)
    !dynamic_enable && self_powered_cfg |=> power.max_power == $past(s_q.regs.self_max_power))
    else $error("self max power not selected");

  chk_self_ctrl: assert property (@(posedge clk) disable iff (reset)
    self_sel |=> power.ctrl_current == $past(s_q.regs.self_ctrl_current))
    else $error("self controller current not selected");

  chk_zero_delay_good: assert property (@(posedge clk) disable iff (reset)
    port_power_start && s_q.regs.power_good_delay == 8'h00 |=> port_power_good)
    else $error("zero delay did not give power good");

  chk_delay_not_early: assert property (@(posedge clk) disable iff (reset)
    port_power_start && s_q.regs.power_good_delay != 8'h00 |=> !port_power_good)
    else $error("power good before delay elapsed");

  cov_undef_write: cover property (@(posedge clk)
    req.wr_en && !(req.addr inside {[8'h0B:8'h10]}));
  cov_dynamic_swap: cover property (@(posedge clk) dynamic_enable ##1 $changed(self_sel));
  cov_port_disabled: cover property (@(posedge clk) power.port_enable == 3'b000);
  cov_power_good: cover property (@(posedge clk) $rose(port_power_good));
  // Compound flag feeds only this cover, not the figures; the host accounts for the peripheral
  cov_compound_self: cover property (@(posedge clk) compound_device && power.self_mode);

endmodule : hpc_power_regs
